// ---- core/bcd_calendar_clock_core.sv ----
// Calendar core: BCD time and date, write checking, key lock, event pin.
// Assumes software writes arrive on clk; oscillators are asynchronous pins.
`timescale 1ns/1ps

module bcd_calendar_clock_core #(
    parameter int unsigned PRESCALE = 32768, // Slow edges per second.
    parameter int unsigned GUARD = 8 // Slow edges of closed window.
) (
    input wire logic clk, // Core clock, 250 MHz.
    input wire logic rstn, // Power-on reset, active low.
    input wire rtc_cal_pkg::wr_t wr, // Register write from software.
    input wire logic slowExtOsc, // External slow oscillator pin.
    input wire logic slowIntOsc, // Internal slow oscillator pin.
    input wire logic alarmAFlag, // Alarm A match flag.
    input wire logic alarmBFlag, // Alarm B match flag.
    input wire logic wakeFlag, // Wake-up timer overflow flag.
    output rtc_cal_pkg::time_t curTime, // Current time.
    output rtc_cal_pkg::date_t curDate, // Current date.
    output logic hourFormat24, // Hour format select.
    output logic running, // Calendar counting.
    output logic windowOpen, // Safe access window.
    output logic writeLocked, // Registers write-protected.
    output logic accessReq, // Access request flag.
    output logic writeRejected, // Pulse: illegal value dropped.
    output logic eventPin // Event output pin.
);
    import rtc_cal_pkg::*;

    localparam int CW = $clog2(PRESCALE); // Prescaler width.
    localparam logic [CW-1:0] LAST = CW'(PRESCALE - 1); // Last count.
    localparam logic [CW-1:0] SHUT = CW'(PRESCALE - GUARD); // Window end.

    // All state of the core.
    typedef struct packed {
        time_t tm; // Time.
        date_t dt; // Date.
        logic h24; // Hour format select.
        logic run; // Counting enabled.
        logic [2:0] src; // Clock source.
        logic acc; // Access request flag.
        logic [1:0] outSel; // Output select field.
        logic locked; // Write protection.
        logic armed; // First key byte seen.
        logic ext1, ext2, int1, int2; // Oscillator synchronisers.
        logic selPrev; // Selected oscillator, one cycle old.
        logic [CW-1:0] pre; // Slow edge prescaler.
        logic secTick; // One-cycle second marker.
        logic win; // Safe access window.
        logic rej; // Rejected write pulse.
        logic evt; // Event pin.
    } state_t;

    state_t st; // Registered state.
    state_t next_st; // Next state.

    ////////////////////////////////////////////////////////////////////////
    // Helpers for BCD arithmetic and checks.

    // A byte is two BCD digits no greater than the limit.
    function automatic logic bcdOk(input logic [7:0] v,
                                   input logic [7:0] lim);
        return v[3:0] <= 4'h9 && v[7:4] <= 4'h9 && v <= lim;
    endfunction

    // Add one to a BCD byte.
    function automatic logic [7:0] bcdInc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return v + 8'h01;
    endfunction

    // An hour is legal in the chosen form.
    function automatic logic hourOk(input logic [7:0] h, input logic f24);
        if (f24) begin
            return bcdOk(h, MAX_H24);
        end
        // Bit 5 is the meridiem flag, the rest reads 01..12.
        return h[7:6] == 2'h0 && h[4:0] != 5'h0 &&
               bcdOk({3'h0, h[4:0]}, MAX_H12);
    endfunction

    // Years divisible by four are leap years across 00..99.
    function automatic logic isLeap(input logic [7:0] y);
        return y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 ||
                       y[3:0] == 4'h8);
    endfunction

    // Last day of a month, BCD.
    function automatic logic [7:0] lastDay(input logic [7:0] m,
                                           input logic [7:0] y);
        if (m == 8'h02) begin
            return isLeap(y) ? 8'h29 : 8'h28;
        end
        if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
            return 8'h30;
        end
        return MAX_DAY;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // Every register update is computed here; the order matters, since
    // a software write in the same cycle as a second tick must win.
    always_comb begin
        logic sel; // Selected oscillator level.
        logic dayUp; // Midnight passed.
        logic ok; // Write value legal.
        time_t wt; // Time as written.
        date_t wd; // Date as written.
        sel = 1'b0;
        dayUp = 1'b0;
        ok = 1'b0;
        wt = time_t'(wr.data[23:0]);
        wd = '{year: wr.data[23:16], month: wr.data[15:8],
               day: wr.data[7:0], week: wr.data[26:24]};
        next_st = st;
        next_st.rej = 1'b0;
        next_st.secTick = 1'b0;

        // Two flip-flops on each oscillator pin before any use.
        next_st.ext1 = slowExtOsc;
        next_st.ext2 = st.ext1;
        next_st.int1 = slowIntOsc;
        next_st.int2 = st.int1;

        // Only a slow oscillator drives the calendar; any other source
        // leaves the prescaler idle.
        if (st.src == SRC_EXT_SLOW) begin
            sel = st.ext2;
        end else if (st.src == SRC_INT_SLOW) begin
            sel = st.int2;
        end
        next_st.selPrev = sel;

        // Count rising slow edges into whole seconds.
        if (st.run && sel && !st.selPrev) begin
            if (st.pre == LAST) begin
                next_st.pre = '0;
                next_st.secTick = 1'b1;
            end else begin
                next_st.pre = st.pre + CW'(1);
            end
        end

        // The window shuts a few slow edges before each update and stays
        // shut through the tick cycle itself, so software never reads a
        // half-advanced calendar.
        next_st.win = !(st.run && (next_st.pre >= SHUT ||
                                   next_st.secTick));

        // Advance the calendar on each second.
        if (st.secTick) begin
            next_st.tm.sec = bcdInc(st.tm.sec);
            if (st.tm.sec == MAX_SEC) begin
                next_st.tm.sec = 8'h00;
                next_st.tm.min = bcdInc(st.tm.min);
                if (st.tm.min == MAX_SEC) begin
                    next_st.tm.min = 8'h00;
                    if (st.h24) begin
                        // 23 rolls to 00 and the day moves on.
                        next_st.tm.hour = bcdInc(st.tm.hour);
                        if (st.tm.hour == MAX_H24) begin
                            next_st.tm.hour = 8'h00;
                            dayUp = 1'b1;
                        end
                    end else if (st.tm.hour[4:0] == 5'h12) begin
                        // Twelve goes to one with the same meridiem.
                        next_st.tm.hour = (st.tm.hour & PM_BIT) | 8'h01;
                    end else if (st.tm.hour[4:0] == 5'h11) begin
                        // Eleven goes to twelve of the other half day.
                        next_st.tm.hour = st.tm.hour[5] ? MAX_H12
                                        : (MAX_H12 | PM_BIT);
                        dayUp = st.tm.hour[5];
                    end else begin
                        next_st.tm.hour = (st.tm.hour & PM_BIT) |
                                          bcdInc(st.tm.hour & 8'h1F);
                    end
                end
            end
        end

        // Weekday, day, month and year follow midnight.
        if (dayUp) begin
            next_st.dt.week = (st.dt.week == MAX_WEEK) ? 3'h0
                            : st.dt.week + 3'h1;
            next_st.dt.day = bcdInc(st.dt.day);
            if (st.dt.day == lastDay(st.dt.month, st.dt.year)) begin
                next_st.dt.day = RST_DAY;
                next_st.dt.month = bcdInc(st.dt.month);
                if (st.dt.month == MAX_MON) begin
                    next_st.dt.month = RST_MON;
                    next_st.dt.year = (st.dt.year == MAX_YEAR) ? 8'h00
                                    : bcdInc(st.dt.year);
                end
            end
        end

        // Software writes. The key and interrupt clear registers are
        // never protected; everything else needs the lock open.
        if (wr.en) begin
            unique case (wr.sel)
                SEL_KEY: begin
                    if (st.armed) begin
                        next_st.armed = 1'b0;
                        // Exact pair unlocks, anything else relocks.
                        next_st.locked = wr.data[7:0] != KEY_UNLOCK;
                    end else if (wr.data[7:0] == KEY_FIRST) begin
                        next_st.armed = 1'b1;
                    end
                end
                SEL_CR0: begin
                    if (!st.locked) begin
                        next_st.h24 = wr.data[CR0_H24_BIT];
                        next_st.run = wr.data[CR0_START_BIT];
                    end
                end
                SEL_CR1: begin
                    if (!st.locked) begin
                        next_st.acc = wr.data[CR1_ACCESS_BIT];
                        next_st.src = wr.data[CR1_SRC_LSB +: 3];
                    end
                end
                SEL_CR2: begin
                    if (!st.locked) begin
                        next_st.outSel = wr.data[CR2_OUT_LSB +: 2];
                    end
                end
                SEL_TIME: begin
                    ok = bcdOk(wt.sec, MAX_SEC) &&
                         bcdOk(wt.min, MAX_SEC) &&
                         hourOk(wt.hour, st.h24) &&
                         wr.data[31:24] == 8'h00;
                    if (!st.locked && ok) begin
                        next_st.tm = wt;
                    end
                    next_st.rej = !st.locked && !ok;
                end
                SEL_DATE: begin
                    ok = bcdOk(wd.year, MAX_YEAR) &&
                         bcdOk(wd.month, MAX_MON) && wd.month != 8'h00 &&
                         bcdOk(wd.day, MAX_DAY) && wd.day != 8'h00 &&
                         wd.week <= MAX_WEEK;
                    if (!st.locked && ok) begin
                        next_st.dt = wd;
                    end
                    next_st.rej = !st.locked && !ok;
                end
                default: begin
                    // Interrupt clear holds no flag of this core.
                end
            endcase
        end

        // Event pin source.
        unique case (st.outSel)
            OUT_LOW: next_st.evt = 1'b0;
            OUT_ALM_A: next_st.evt = alarmAFlag;
            OUT_ALM_B: next_st.evt = alarmBFlag;
            OUT_WAKE: next_st.evt = wakeFlag;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.

    // Only the power-on reset reaches this flop bank; other resets of
    // the chip are kept away so the calendar keeps time through them.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.tm.hour <= RST_HOUR;
            st.dt.day <= RST_DAY;
            st.dt.month <= RST_MON;
            st.locked <= 1'b1;
            st.win <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign curTime = st.tm;
    assign curDate = st.dt;
    assign hourFormat24 = st.h24;
    assign running = st.run;
    assign windowOpen = st.win;
    assign writeLocked = st.locked;
    assign accessReq = st.acc;
    assign writeRejected = st.rej;
    assign eventPin = st.evt;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    bad_second_a: assert property (
        wr.en && wr.sel == SEL_TIME && wr.data[7:0] == 8'h61
        |=> st.rej || st.locked)
        else $error("Illegal second was not refused.");

    minute_range_a: assert property (
        bcdOk(st.tm.min, MAX_SEC) && bcdOk(st.tm.sec, MAX_SEC))
        else $error("Minute or second left its range.");

    bad_month_a: assert property (
        wr.en && wr.sel == SEL_DATE && wr.data[15:8] == 8'h13
        |=> st.dt.month != 8'h13)
        else $error("Month thirteen was stored.");

    week_range_a: assert property (
        st.dt.week <= MAX_WEEK)
        else $error("Weekday beyond six.");

    hour_form_a: assert property (
        st.h24 |-> st.tm.hour <= MAX_H24)
        else $error("Hour beyond 23 in 24-hour form.");

    noon_roll_a: assert property (
        st.secTick && !st.h24 && !wr.en && st.tm == 24'h115959
        |=> st.tm == 24'h320000)
        else $error("Eleven AM did not roll to 0x32.");

    locked_hold_a: assert property (
        st.locked && wr.en && wr.sel == SEL_CR0 |=> $stable(st.run))
        else $error("Locked control register changed.");

    unlock_pair_a: assert property (
        st.armed && wr.en && wr.sel == SEL_KEY &&
        wr.data[7:0] == KEY_UNLOCK |=> !st.locked)
        else $error("Key pair did not unlock.");

    relock_pair_a: assert property (
        st.armed && wr.en && wr.sel == SEL_KEY &&
        wr.data[7:0] != KEY_UNLOCK |=> st.locked)
        else $error("Key pair did not relock.");

    start_bit_a: assert property (
        !st.locked && wr.en && wr.sel == SEL_CR0 &&
        wr.data[CR0_START_BIT] |=> st.run)
        else $error("Start bit did not start counting.");

    event_sel_a: assert property (
        st.outSel == OUT_ALM_B && $stable(st.outSel)
        |=> st.evt == $past(alarmBFlag))
        else $error("Event pin does not follow alarm B.");

    window_shut_a: assert property (
        st.secTick |-> !st.win)
        else $error("Window open at a calendar update.");

endmodule

// ---- core/rtc_cal_pkg.sv ----
// Shared types and constants of the calendar clock core.
// Assumes one 250 MHz core clock and slow oscillators arriving as pins.
package rtc_cal_pkg;

    // Register selector codes of the plain write port.
    localparam logic [2:0] SEL_KEY = 3'h0; // Key register.
    localparam logic [2:0] SEL_CR0 = 3'h1; // First control register.
    localparam logic [2:0] SEL_CR1 = 3'h2; // Second control register.
    localparam logic [2:0] SEL_CR2 = 3'h3; // Third control register.
    localparam logic [2:0] SEL_TIME = 3'h4; // Time register.
    localparam logic [2:0] SEL_DATE = 3'h5; // Date register.
    localparam logic [2:0] SEL_ICR = 3'h6; // Interrupt clear register.

    // Key codes.
    localparam logic [7:0] KEY_FIRST = 8'hCA; // Opens a key pair.
    localparam logic [7:0] KEY_UNLOCK = 8'h53; // Second byte that unlocks.

    // Field positions inside the control words.
    localparam int CR0_H24_BIT = 5; // Hour format select.
    localparam int CR0_START_BIT = 7; // Run start.
    localparam int CR1_ACCESS_BIT = 1; // Access request flag.
    localparam int CR1_SRC_LSB = 8; // Clock source select, 3 bits.
    localparam int CR2_OUT_LSB = 0; // Output select field, 2 bits.

    // Clock source codes.
    localparam logic [2:0] SRC_EXT_SLOW = 3'h0; // External slow osc.
    localparam logic [2:0] SRC_INT_SLOW = 3'h2; // Internal slow osc.

    // Output select codes.
    localparam logic [1:0] OUT_LOW = 2'h0; // Constant low.
    localparam logic [1:0] OUT_ALM_A = 2'h1; // Alarm A match flag.
    localparam logic [1:0] OUT_ALM_B = 2'h2; // Alarm B match flag.
    localparam logic [1:0] OUT_WAKE = 2'h3; // Wake-up overflow flag.

    // BCD limits and values after reset.
    localparam logic [7:0] MAX_SEC = 8'h59; // Seconds and minutes.
    localparam logic [7:0] MAX_H24 = 8'h23; // Hours, 24-hour form.
    localparam logic [7:0] MAX_H12 = 8'h12; // Hours, 12-hour form.
    localparam logic [7:0] MAX_DAY = 8'h31; // Day of month.
    localparam logic [7:0] MAX_MON = 8'h12; // Month.
    localparam logic [7:0] MAX_YEAR = 8'h99; // Year.
    localparam logic [2:0] MAX_WEEK = 3'h6; // Saturday.
    localparam logic [7:0] PM_BIT = 8'h20; // Meridiem flag of the hour.
    localparam logic [7:0] RST_HOUR = 8'h00; // Hour after reset.
    localparam logic [7:0] RST_DAY = 8'h01; // Day after reset.
    localparam logic [7:0] RST_MON = 8'h01; // Month after reset.

    // Time of day, BCD.
    typedef struct packed {
        logic [7:0] hour; // Hour, bit 5 is PM in 12-hour form.
        logic [7:0] min; // Minutes.
        logic [7:0] sec; // Seconds.
    } time_t;

    // Calendar date, BCD.
    typedef struct packed {
        logic [7:0] year; // Year 00..99.
        logic [7:0] month; // Month 01..12.
        logic [7:0] day; // Day 01..31.
        logic [2:0] week; // Weekday, 0 is Sunday.
    } date_t;

    // One register write from software.
    typedef struct packed {
        logic en; // Write strobe.
        logic [2:0] sel; // Register selector.
        logic [31:0] data; // Write data.
    } wr_t;

endpackage

// ---- verif/bcd_calendar_clock_core_bench.sv ----
// Self-checking bench of the calendar clock core: writes, lock, counting.
// Assumes rtc_cal_pkg is compiled first; runs the core with a short second.
`timescale 1ns/1ps

`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin \
    fails++; $display("wrong value %s expected %0h seen %0h", what, exp, \
    got); end end

module bcd_calendar_clock_core_bench;
    import rtc_cal_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // A short second keeps every rollover scenario to a few dozen cycles.
    localparam int unsigned PRE = 4; // Slow edges per second in this run.
    logic clk = 1'b0; // Core clock.
    logic rstn = 1'b0; // Power-on reset.
    wr_t wr = '0; // Software write port.
    logic slowExtOsc = 1'b0; // External slow oscillator.
    logic slowIntOsc = 1'b0; // Internal slow oscillator.
    logic alarmAFlag = 1'b0; // Alarm A flag.
    logic alarmBFlag = 1'b0; // Alarm B flag.
    logic wakeFlag = 1'b0; // Wake-up flag.
    time_t curTime; // Current time.
    date_t curDate; // Current date.
    logic hourFormat24, running, windowOpen, writeLocked, accessReq;
    logic writeRejected, eventPin; // Pulse of a dropped write, event pin.
    int fails = 0; // Mismatches.
    int checks = 0; // Comparisons.
    int cycles = 0; // Timeout counter.
    int rejCount = 0; // Pulses of writeRejected seen.
    logic winClosed = 1'b0; // Window seen closed while running.
    logic [2:0] fl; // Flag pattern for the event pin.
    logic ex; // Expected event pin.
    // Illegal writes; each must leave time and date untouched.
    logic [34:0] badW [0:9] = '{{SEL_TIME, 32'h00235961},
        {SEL_TIME, 32'h00236059}, {SEL_TIME, 32'h00245959},
        {SEL_TIME, 32'h0023595A}, {SEL_DATE, 32'h03991331},
        {SEL_DATE, 32'h03990031}, {SEL_DATE, 32'h03991232},
        {SEL_DATE, 32'h03991200}, {SEL_DATE, 32'h07991231},
        {SEL_DATE, 32'h03A01231}};

    bcd_calendar_clock_core #(.PRESCALE(PRE), .GUARD(1))
        bcd_calendar_clock_core_inst (.clk(clk), .rstn(rstn), .wr(wr),
        .slowExtOsc(slowExtOsc), .slowIntOsc(slowIntOsc),
        .alarmAFlag(alarmAFlag), .alarmBFlag(alarmBFlag),
        .wakeFlag(wakeFlag), .curTime(curTime), .curDate(curDate),
        .hourFormat24(hourFormat24), .running(running),
        .windowOpen(windowOpen), .writeLocked(writeLocked),
        .accessReq(accessReq), .writeRejected(writeRejected),
        .eventPin(eventPin));

    ////////////////////////////////////////////////////////////////////////
    // Clock, pulse monitors and the hang guard.
    always #2 clk = ~clk;

    // The reject flag lasts one cycle, so it is counted at every edge.
    always @(posedge clk) begin
        cycles++;
        if (writeRejected === 1'b1) begin
            rejCount++;
        end
        if (running === 1'b1 && windowOpen === 1'b0) begin
            winClosed = 1'b1;
        end
        if (cycles >= 6000) begin
            fails++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One write: strobe for a single edge, then an idle edge after it.
    task automatic wrReg(input logic [2:0] s, input logic [31:0] d);
        @(posedge clk);
        wr <= '{en: 1'b1, sel: s, data: d};
        @(posedge clk);
        wr <= '0;
    endtask

    // Lets the last write land before outputs are looked at.
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Polls the safe window the way software does: up to 1000 looks,
    // spaced a few cycles apart, then gives up and reports it.
    task automatic waitWindow();
        int n;
        n = 0;
        while (windowOpen !== 1'b1 && n < 1000) begin
            repeat (4) @(posedge clk);
            #1;
            n++;
        end
        `CHK("window", 1'b1, windowOpen)
    endtask

    // Slow edges with a high phase of three core cycles and a low phase of four.
    task automatic oscTicks(input int n, input bit useInt);
        repeat (n) begin
            @(posedge clk);
            {slowIntOsc, slowExtOsc} <= useInt ? 2'b10 : 2'b01;
            repeat (3) @(posedge clk);
            {slowIntOsc, slowExtOsc} <= 2'b00;
            repeat (3) @(posedge clk);
        end
        repeat (8) @(posedge clk);
        #1;
    endtask

    // Date word layout differs from the struct order, so rebuild it.
    function automatic date_t mkDate(input logic [31:0] d);
        return '{year: d[23:16], month: d[15:8], day: d[7:0],
            week: d[26:24]};
    endfunction

    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        settle();
        `CHK("time", 24'h000000, curTime)
        `CHK("date", mkDate(32'h00000101), curDate)
        `CHK("locked", 1'b1, writeLocked)
        `CHK("run", 1'b0, running)
        // Writes while locked, and a lone second key byte, change nothing.
        wrReg(SEL_TIME, 32'h00123456);
        wrReg(SEL_CR0, 32'h000000A0);
        wrReg(SEL_KEY, {24'h0, KEY_UNLOCK});
        settle();
        `CHK("time", 24'h000000, curTime)
        `CHK("run", 1'b0, running)
        `CHK("locked", 1'b1, writeLocked)
        wrReg(SEL_KEY, 32'h000000CA);
        wrReg(SEL_KEY, 32'h00000053);
        settle();
        `CHK("locked", 1'b0, writeLocked)
        // Largest legal values in 24-hour form are taken.
        wrReg(SEL_CR0, 32'h00000020);
        wrReg(SEL_TIME, 32'h00235959);
        wrReg(SEL_DATE, 32'h03991231);
        settle();
        `CHK("h24", 1'b1, hourFormat24)
        `CHK("time", 24'h235959, curTime)
        `CHK("date", mkDate(32'h03991231), curDate)
        for (int i = 0; i < 10; i++) begin
            wrReg(badW[i][34:32], badW[i][31:0]);
            settle();
            `CHK("time", 24'h235959, curTime)
            `CHK("date", mkDate(32'h03991231), curDate)
            `CHK("rejects", i + 1, rejCount)
        end
        // In 12-hour form 13 and 0 are illegal, 0x32 is noon.
        wrReg(SEL_CR0, 32'h00000000);
        wrReg(SEL_TIME, 32'h00133000);
        wrReg(SEL_TIME, 32'h00003000);
        wrReg(SEL_TIME, 32'h00323000);
        settle();
        `CHK("rejects", 12, rejCount)
        `CHK("time", 24'h323000, curTime)
        // Morning rolls into noon; the window closes near the tick.
        // The source is chosen while both oscillators idle steadily, then
        // time is loaded and counting started, in the usual order.
        wrReg(SEL_CR1, 32'h00000000);
        wrReg(SEL_TIME, 32'h00115959);
        wrReg(SEL_CR0, 32'h00000080);
        settle();
        `CHK("run", 1'b1, running)
        oscTicks(PRE, 1'b0);
        `CHK("time", 24'h320000, curTime)
        `CHK("window", 1'b1, winClosed)
        `CHK("window", 1'b1, windowOpen)
        // Late evening rolls to midnight 0x12 and a leap-year day 29.
        wrReg(SEL_CR0, 32'h00000000);
        wrReg(SEL_TIME, 32'h00315959);
        wrReg(SEL_DATE, 32'h02240228);
        wrReg(SEL_CR0, 32'h00000080);
        oscTicks(PRE, 1'b0);
        `CHK("time", 24'h120000, curTime)
        `CHK("date", mkDate(32'h03240229), curDate)
        // A common year skips to March; Saturday wraps to Sunday.
        wrReg(SEL_CR0, 32'h00000020);
        wrReg(SEL_TIME, 32'h00235959);
        wrReg(SEL_DATE, 32'h06230228);
        wrReg(SEL_CR0, 32'h000000A0);
        oscTicks(PRE, 1'b0);
        `CHK("time", 24'h000000, curTime)
        `CHK("date", mkDate(32'h00230301), curDate)
        // Only the selected slow oscillator advances the calendar.
        wrReg(SEL_CR1, 32'h00000200);
        oscTicks(PRE, 1'b0);
        `CHK("time", 24'h000000, curTime)
        oscTicks(PRE, 1'b1);
        `CHK("time", 24'h000001, curTime)
        wrReg(SEL_CR1, 32'h00000100);
        oscTicks(PRE, 1'b1);
        `CHK("time", 24'h000001, curTime)
        // A bracketed access: poll the window, raise the flag, then drop
        // it a few cycles later, far inside one second.
        waitWindow();
        wrReg(SEL_CR1, 32'h00000102);
        settle();
        `CHK("access", 1'b1, accessReq)
        wrReg(SEL_CR1, 32'h00000100);
        settle();
        `CHK("access", 1'b0, accessReq)
        // Two reads in a row agree while nothing counts.
        `CHK("time", 24'h000001, curTime)
        @(posedge clk);
        #1;
        `CHK("time", 24'h000001, curTime)
        // Every output select code against two flag patterns.
        for (int p = 0; p < 2; p++) begin
            fl = (p == 0) ? 3'b101 : 3'b010;
            @(posedge clk);
            {alarmAFlag, alarmBFlag, wakeFlag} <= fl;
            for (int s = 0; s < 4; s++) begin
                wrReg(SEL_CR2, 32'(s));
                settle();
                ex = (s == 0) ? 1'b0 : fl[3 - s];
                `CHK("event", ex, eventPin)
            end
        end
        // Key then any other byte relocks; later writes are ignored.
        wrReg(SEL_KEY, 32'h000000CA);
        wrReg(SEL_KEY, 32'h00000000);
        wrReg(SEL_TIME, 32'h00111111);
        wrReg(SEL_ICR, 32'h0000003F);
        settle();
        `CHK("locked", 1'b1, writeLocked)
        `CHK("time", 24'h000001, curTime)
        // A second power-on reset mid-run brings back every default.
        @(posedge clk);
        rstn <= 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        settle();
        `CHK("run", 1'b0, running)
        `CHK("date", mkDate(32'h00000101), curDate)
        `CHK("locked", 1'b1, writeLocked)
        end_sim();
    end

endmodule
